//--- inc/e1_alarm_map.svh
`ifndef E1_ALARM_MAP_SVH
`define E1_ALARM_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define MASK_OFFSET 12'h008
`define ALIGN_OFFSET 12'h00C

// ****************************************
// alarm_generation_control fields
// ****************************************
`define TEST_PAT_BIT 7
`define LOF_CRIT_BIT 6
`define REMOTE_SEL_MSB 5
`define REMOTE_SEL_LSB 4
`define CTRL_RESET 8'h00
`define CTRL_WMASK 8'hF0

// ****************************************
// status / mask fields
// ****************************************
`define EV_LOF_BIT 0
`define EV_SEARCH_BIT 1
`define EV_CAS_BIT 2
`define EV_RESET 3'h0

// ****************************************
// frame positions, bits counted 1..8 as 0..7
// ****************************************
`define TS_ALARM 5'h00
`define TS_CAS 5'h10
`define ALARM_BIT_IDX 3'h2
`define MF_ALARM_BIT_IDX 3'h5
`define MF_FRAME0 4'h0

// ****************************************
// timing
// ****************************************
`define CLK_MHZ 100
`define CRC_LOST_MS 8
`define CRC_LOST_CYCLES (`CRC_LOST_MS * `CLK_MHZ * 1000)

`endif

//--- inc/e1_alarm_pkg.sv
package e1_alarm_pkg;

    typedef enum logic [1:0] {
        REMOTE_OFF,
        REMOTE_AUTO,
        REMOTE_FORCED
    } remote_alarm_select_e;

    typedef enum logic [1:0] {
        CRC_IDLE,
        CRC_TIMING,
        CRC_EXPIRED
    } crc_watch_e;

    // position of the bit currently offered on tx_data_in
    typedef struct packed {
        logic [4:0] ts;
        logic [2:0] bit_idx;
        logic fas_frame;
        logic [3:0] mf_frame;
    } tx_pos_s;

    // receive alignment defects, level while lost
    typedef struct packed {
        logic fas_lost;
        logic crc_mf_lost;
        logic cas_mf_lost;
    } rx_align_s;

endpackage : e1_alarm_pkg

//--- src/e1_alarm_generation_control.sv
`timescale 1ns/1ps
`include "e1_alarm_map.svh"
// Contract
// - control bit 7 set replaces outbound traffic by the test pattern.
// - test pattern is unframed 1,0,1,0 repeating, no alignment overhead.
// - bit 6 zero: CRC multiframe or FAS loss declares LOF at once.
// - bit 6 one: only FAS alignment loss declares LOF at once.
// - bit 6 one: CRC multiframe lost over 8 ms forces a frame search.
// - yellow field 00 or 10 sends neither yellow alarm.
// - field 11: timeslot 0 bit 3 of non-FAS frames is one while FAS lost.
// - field 11: timeslot 16 bit 6 of frame 0 is one while CAS MF lost.
// - forced setting sends both yellow bits as constant ones.
module e1_alarm_generation_control #(
    parameter int unsigned CRC_LOST_CYC = `CRC_LOST_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_data_in,
    input wire e1_alarm_pkg::tx_pos_s tx_pos,
    input wire e1_alarm_pkg::rx_align_s rx_align,
    output logic tx_data_out,
    output logic lof_declared,
    output logic frame_search,
    output logic irq
);

    // ****************************************
    // register bus
    // ****************************************
    logic [7:0] ctrl_reg, ctrl_next;
    logic [2:0] status_reg, status_next;
    logic [2:0] mask_reg, mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic setup, access, mapped;
    logic [2:0] events;

    // no wait state: data is looked up in setup, answered in the first access cycle
    always_comb begin
        setup = psel && !penable;
        access = psel && penable && pready_reg;
        mapped = (paddr == `CTRL_OFFSET) || (paddr == `STATUS_OFFSET) ||
                 (paddr == `MASK_OFFSET) || (paddr == `ALIGN_OFFSET);
        pready_next = setup;
        pslverr_next = setup && !mapped;
        prdata_next = prdata_reg;
        if (setup) begin
            case (paddr)
                `CTRL_OFFSET: prdata_next = {24'h00_0000, ctrl_reg};
                `STATUS_OFFSET: prdata_next = {29'h0000_0000, status_reg};
                `MASK_OFFSET: prdata_next = {29'h0000_0000, mask_reg};
                `ALIGN_OFFSET: prdata_next = {27'h000_0000, frame_search,
                    lof_declared, rx_align};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        if (access && pwrite && paddr == `CTRL_OFFSET) begin
            // only the alarm bits live here; low nibble reads zero
            ctrl_next = pwdata[7:0] & `CTRL_WMASK;
        end
        if (access && pwrite && paddr == `MASK_OFFSET) begin
            mask_next = pwdata[2:0];
        end
        // a new event in the clearing cycle survives
        status_next = status_reg | events;
        if (access && !pwrite && paddr == `STATUS_OFFSET) begin
            status_next = (status_reg & ~prdata_reg[2:0]) | events;
        end
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RESET;
            status_reg <= `EV_RESET;
            mask_reg <= `EV_RESET;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;

    // ****************************************
    // receive loss of frame and crc watch
    // ****************************************
    e1_alarm_pkg::crc_watch_e crc_state_reg, crc_state_next;
    logic [19:0] crc_cnt_reg, crc_cnt_next;
    logic lof_reg, lof_next;
    logic search_reg, search_next;
    logic cas_prev_reg, cas_prev_next;
    logic crit;

    always_comb begin
        crit = ctrl_reg[`LOF_CRIT_BIT];
        if (crit) begin
            lof_next = rx_align.fas_lost;
        end else begin
            lof_next = rx_align.fas_lost ||
                       rx_align.crc_mf_lost;
        end
        crc_state_next = crc_state_reg;
        crc_cnt_next = crc_cnt_reg;
        search_next = 1'b0;
        cas_prev_next = rx_align.cas_mf_lost;
        // the search is asked once per outage; recovery rearms it
        case (crc_state_reg)
            e1_alarm_pkg::CRC_IDLE: begin
                crc_cnt_next = 20'h0_0000;
                if (crit && rx_align.crc_mf_lost) begin
                    crc_state_next = e1_alarm_pkg::CRC_TIMING;
                end
            end
            e1_alarm_pkg::CRC_TIMING: begin
                if (!crit || !rx_align.crc_mf_lost) begin
                    crc_state_next = e1_alarm_pkg::CRC_IDLE;
                end else if (crc_cnt_reg >= CRC_LOST_CYC[19:0]) begin
                    search_next = 1'b1;
                    crc_state_next = e1_alarm_pkg::CRC_EXPIRED;
                end else begin
                    crc_cnt_next = crc_cnt_reg + 20'h0_0001;
                end
            end
            e1_alarm_pkg::CRC_EXPIRED: begin
                if (!crit || !rx_align.crc_mf_lost) begin
                    crc_state_next = e1_alarm_pkg::CRC_IDLE;
                end
            end
            default: crc_state_next = e1_alarm_pkg::CRC_IDLE;
        endcase
        events = 3'h0;
        events[`EV_LOF_BIT] = lof_next && !lof_reg;
        events[`EV_SEARCH_BIT] = search_next;
        events[`EV_CAS_BIT] = rx_align.cas_mf_lost && !cas_prev_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_state_reg <= e1_alarm_pkg::CRC_IDLE;
            crc_cnt_reg <= 20'h0_0000;
            lof_reg <= 1'b0;
            search_reg <= 1'b0;
            cas_prev_reg <= 1'b0;
        end else begin
            crc_state_reg <= crc_state_next;
            crc_cnt_reg <= crc_cnt_next;
            lof_reg <= lof_next;
            search_reg <= search_next;
            cas_prev_reg <= cas_prev_next;
        end
    end

    assign lof_declared = lof_reg;
    assign frame_search = search_reg;

    // ****************************************
    // transmit insertion
    // ****************************************
    e1_alarm_pkg::remote_alarm_select_e alarm_mode;
    logic [1:0] remote_sel;
    logic pat_on;
    logic alt_reg, alt_next;
    logic tx_reg, tx_next;
    logic at_alarm, at_mf_alarm;

    always_comb begin
        remote_sel = ctrl_reg[`REMOTE_SEL_MSB:`REMOTE_SEL_LSB];
        pat_on = ctrl_reg[`TEST_PAT_BIT];
        case (remote_sel)
            2'b11: alarm_mode = e1_alarm_pkg::REMOTE_AUTO;
            2'b01: alarm_mode = e1_alarm_pkg::REMOTE_FORCED;
            default: alarm_mode = e1_alarm_pkg::REMOTE_OFF;
        endcase
        at_alarm = tx_pos.ts == `TS_ALARM && !tx_pos.fas_frame &&
                   tx_pos.bit_idx == `ALARM_BIT_IDX;
        at_mf_alarm = tx_pos.ts == `TS_CAS && tx_pos.mf_frame == `MF_FRAME0 &&
                      tx_pos.bit_idx == `MF_ALARM_BIT_IDX;
        tx_next = tx_data_in;
        alt_next = 1'b1;
        if (pat_on) begin
            // frame position is ignored: the pattern carries no FAS
            tx_next = alt_reg;
            alt_next = !alt_reg;
        end else if (alarm_mode == e1_alarm_pkg::REMOTE_FORCED) begin
            if (at_alarm || at_mf_alarm) begin
                tx_next = 1'b1;
            end
        end else if (alarm_mode == e1_alarm_pkg::REMOTE_AUTO) begin
            if (at_alarm && rx_align.fas_lost) begin
                tx_next = 1'b1;
            end
            if (at_mf_alarm && rx_align.cas_mf_lost) begin
                tx_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_reg <= 1'b1;
            tx_reg <= 1'b0;
        end else begin
            alt_reg <= alt_next;
            tx_reg <= tx_next;
        end
    end

    assign tx_data_out = tx_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_pat_two;
        pat_on ##1 pat_on;
    endsequence

    a_pattern_alternates: assert property (
        s_pat_two |=> tx_data_out != $past(tx_data_out))
        else $error("test pattern did not alternate");

    a_pattern_starts_one: assert property (
        !pat_on ##1 pat_on |=> tx_data_out)
        else $error("test pattern did not start with one");

    a_pattern_off_pass: assert property (
        !pat_on && alarm_mode == e1_alarm_pkg::REMOTE_OFF
        |=> tx_data_out == $past(tx_data_in))
        else $error("traffic not passed with pattern off");

    a_lof_any_loss: assert property (
        !ctrl_reg[`LOF_CRIT_BIT] && rx_align.crc_mf_lost |=> lof_declared)
        else $error("crc loss did not declare lof");

    a_lof_fas_only: assert property (
        ctrl_reg[`LOF_CRIT_BIT] && !rx_align.fas_lost |=> !lof_declared)
        else $error("lof declared without fas loss");

    a_search_timer: assert property (
        frame_search |-> $past(crc_cnt_reg) == CRC_LOST_CYC[19:0]
        && $past(rx_align.crc_mf_lost))
        else $error("frame search at wrong time");

    a_yellow_auto: assert property (
        !pat_on && alarm_mode == e1_alarm_pkg::REMOTE_AUTO && at_alarm
        && !at_mf_alarm |=> tx_data_out ==
        ($past(rx_align.fas_lost) || $past(tx_data_in)))
        else $error("yellow bit wrong in auto mode");

    a_mf_yellow_auto: assert property (
        !pat_on && remote_sel == 2'b11 && at_mf_alarm
        && rx_align.cas_mf_lost |=> tx_data_out)
        else $error("multiframe yellow not sent");

    a_mf_yellow_idle: assert property (
        !pat_on && remote_sel == 2'b11 && at_mf_alarm
        && !rx_align.cas_mf_lost |=> tx_data_out == $past(tx_data_in))
        else $error("multiframe yellow sent while aligned");

    a_yellow_forced: assert property (
        !pat_on && remote_sel == 2'b01 && (at_alarm || at_mf_alarm)
        |=> tx_data_out)
        else $error("forced yellow not sent");

    a_yellow_off: assert property (
        !pat_on && !remote_sel[0] |=> tx_data_out == $past(tx_data_in))
        else $error("yellow sent while disabled");

    a_lof_fas_any: assert property (
        rx_align.fas_lost |=> lof_declared)
        else $error("fas loss did not declare lof");

    // one pulse per outage, so software sees one event, not a storm
    a_search_once: assert property (
        frame_search |=> !frame_search)
        else $error("frame search pulse too long");

endmodule : e1_alarm_generation_control

//--- test/e1_line_model.sv
`timescale 1ns/1ps
// ****************************************
// line side: frame position source and alignment levels
// ****************************************
module e1_line_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fas_cmd,
    input wire logic crc_cmd,
    input wire logic cas_cmd,
    output logic tx_data_in,
    output e1_alarm_pkg::tx_pos_s tx_pos,
    output e1_alarm_pkg::rx_align_s rx_align
);
    logic [12:0] cnt_reg;
    // payload is one in odd timeslots only: both alarm slots are even,
    // so an inserted one stands out and a stuck output cannot pass
    assign tx_data_in = cnt_reg[3];
    assign tx_pos.bit_idx = cnt_reg[2:0];
    assign tx_pos.ts = cnt_reg[7:3];
    assign tx_pos.fas_frame = ~cnt_reg[8];
    assign tx_pos.mf_frame = cnt_reg[12:9];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 13'h0000;
            rx_align <= '0;
        end else begin
            cnt_reg <= cnt_reg + 13'h0001;
            rx_align.fas_lost <= fas_cmd;
            rx_align.crc_mf_lost <= crc_cmd;
            rx_align.cas_mf_lost <= cas_cmd;
        end
    end
endmodule : e1_line_model

//--- test/e1_alarm_generation_control_bench.sv
`timescale 1ns/1ps
`define CHECK_EQ(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) begin \
            fail_count++; \
            $display("ERROR %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module e1_alarm_generation_control_bench;
    localparam int CLC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, tx_data_in, tx_data_out;
    logic lof_declared, frame_search, irq;
    logic fas_cmd = 1'b0;
    logic crc_cmd = 1'b0;
    logic cas_cmd = 1'b0;
    logic mon_on = 1'b0;
    logic exp_f, exp_c, exp_b;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int n_tests = 0;
    int np, first;
    e1_alarm_pkg::tx_pos_s tx_pos, pos_q;
    e1_alarm_pkg::rx_align_s rx_align;

    e1_alarm_generation_control #(.CRC_LOST_CYC(CLC)) dut_u (.clk(clk),
        .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_data_in(tx_data_in), .tx_pos(tx_pos),
        .rx_align(rx_align), .tx_data_out(tx_data_out),
        .lof_declared(lof_declared), .frame_search(frame_search), .irq(irq));
    e1_line_model line_u (.clk(clk), .rst_n(rst_n), .fas_cmd(fas_cmd),
        .crc_cmd(crc_cmd), .cas_cmd(cas_cmd), .tx_data_in(tx_data_in),
        .tx_pos(tx_pos), .rx_align(rx_align));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // apb master: setup, access, wait for pready under a bound
    // ****************************************
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (i == 20) begin
            fail_count++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex);
        apb(a, 1'b0, 32'h0000_0000);
        `CHECK_EQ("rdata", ex, rd)
    endtask : rd_chk

    // line monitor: alarm positions carry the yellow bits, rest payload
    always @(posedge clk) begin
        if (mon_on) begin
            if (pos_q.ts == 5'h00 && pos_q.bit_idx == 3'h2
                    && !pos_q.fas_frame) begin
                `CHECK_EQ("alm", exp_f, tx_data_out)
            end else if (pos_q.ts == 5'h10 && pos_q.bit_idx == 3'h5
                    && pos_q.mf_frame == 4'h0) begin
                `CHECK_EQ("mfalm", exp_c, tx_data_out)
            end else begin
                `CHECK_EQ("payload", pos_q.ts[0], tx_data_out)
            end
        end
        pos_q <= tx_pos;
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(12'h000, 32'h0000_0000);
        rd_chk(12'h008, 32'h0000_0000);
        apb(12'h010, 1'b0, 32'h0000_0000);
        `CHECK_EQ("err", 1'b1, er)
        `CHECK_EQ("errdata", 32'h0000_0000, rd)
        apb(12'h000, 1'b1, 32'h0000_00FF);
        rd_chk(12'h000, 32'h0000_00F0);
        // test pattern overrides forced yellow too
        apb(12'h000, 1'b1, 32'h0000_0090);
        exp_b = 1'b1;
        repeat (64) begin
            @(posedge clk);
            #1;
            `CHECK_EQ("pattern", exp_b, tx_data_out)
            exp_b = ~exp_b;
        end
        // every yellow code, alignment held and lost
        for (int m = 0; m < 8; m++) begin
            apb(12'h000, 1'b1, {26'h0, m[2:1], 4'h0});
            // fas and cas lost apart, so a crossed alarm bit shows
            fas_cmd <= m[0];
            cas_cmd <= !m[0];
            exp_b = m[2:1] == 2'b01;
            exp_f = exp_b | ((m[2:1] == 2'b11) & m[0]);
            exp_c = exp_b | ((m[2:1] == 2'b11) & !m[0]);
            repeat (4) @(posedge clk);
            mon_on <= 1'b1;
            repeat (4096) @(posedge clk);
            mon_on <= 1'b0;
        end
        fas_cmd <= 1'b0;
        cas_cmd <= 1'b0;
        apb(12'h000, 1'b1, 32'h0000_0000);
        apb(12'h008, 1'b1, 32'h0000_0001);
        rd_chk(12'h008, 32'h0000_0001);
        rd_chk(12'h004, 32'h0000_0005);
        crc_cmd <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHECK_EQ("lof", 1'b1, lof_declared)
        @(posedge clk);
        #1;
        `CHECK_EQ("irq", 1'b1, irq)
        rd_chk(12'h004, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHECK_EQ("irqclr", 1'b0, irq)
        crc_cmd <= 1'b0;
        apb(12'h000, 1'b1, 32'h0000_0040);
        crc_cmd <= 1'b1;
        np = 0;
        first = 0;
        for (int k = 1; k < CLC + 12; k++) begin
            @(posedge clk);
            #1;
            if (k == 2) begin
                `CHECK_EQ("lofcrc", 1'b0, lof_declared)
            end
            if (frame_search === 1'b1) begin
                np++;
                first = (first == 0) ? k : first;
            end
        end
        `CHECK_EQ("search", 1, np)
        `CHECK_EQ("searchlate", 1'b1, first > CLC)
        fas_cmd <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHECK_EQ("loffas", 1'b1, lof_declared)
        rd_chk(12'h004, 32'h0000_0003);
        rd_chk(12'h00C, 32'h0000_000E);
        print_verdict();
    end
endmodule : e1_alarm_generation_control_bench
